// *** counter_array_consts.svh ***
// constants for the counter array flags and mode block
// assumes the special function register bus is eight bits wide
`ifndef COUNTER_ARRAY_CONSTS_SVH
`define COUNTER_ARRAY_CONSTS_SVH

// register addresses on the special function register bus
`define CA_MODE_ADDR 8'hD9
`define CA_FLAGS_ADDR 8'hD8

// mode register fields
`define CA_MODE_IDLE_BIT 7
`define CA_MODE_WDOG_BIT 6
`define CA_MODE_LOCK_BIT 5
`define CA_MODE_SEL_HI 3
`define CA_MODE_SEL_LO 1
`define CA_MODE_OVF_IE_BIT 0
`define CA_MODE_RESET 8'h40

// control and flags register fields
`define CA_FLAGS_OVF_BIT 7
`define CA_FLAGS_RUN_BIT 6
`define CA_FLAGS_EVT_HI 5
`define CA_FLAGS_RESET 8'h00

// timebase select codes
`define CA_TB_SYS_DIV12 3'h0
`define CA_TB_SYS_DIV4 3'h1
`define CA_TB_TIMER0 3'h2
`define CA_TB_EXT_FALL 3'h3
`define CA_TB_SYS 3'h4
`define CA_TB_EXT_DIV8 3'h5
`define CA_TB_RTC_DIV8 3'h6

// system clock prescaler counts
`define CA_DIV12_COUNT 4'hC
`define CA_DIV4_COUNT 4'h4

`endif

// *** counter_array_flags_mode.sv ***
// event flags, mode register and timebase tick of the counter array
// assumes a single-cycle special function register bus on the system clock;
// event strobes, module interrupt enables and idle come from logic on this clock
`timescale 1ns/1ps
`include "counter_array_consts.svh"

// What this block does
// [R1] any set module flag with its interrupt enabled raises the shared request
// [R2] module flags clear only when software writes them to zero
// [R3] mode register bit 7 at address D9 holds the idle suspend setting
// [R4] idle suspend clear: counter keeps counting during processor idle
// [R5] watchdog use enable set turns module 5 into the watchdog
// [R6] idle suspend set: counting stops during idle, resumes afterwards
// [R7] a match or capture strobe from a module sets its flag
// [R8] mode bits 3 to 1 select the counter timebase source
module counter_array_flags_mode
#(
   parameter int NUM_MODULES = 6
)
(
   input wire logic clock,
   input wire logic srst,
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   output counter_array_pkg::sfr_byte_t sfr_rdata,
   input wire logic [NUM_MODULES-1:0] module_event,
   input wire logic [NUM_MODULES-1:0] module_irq_enable,
   input wire logic counter_overflow,
   input wire logic cpu_idle,
   input wire logic timer0_overflow,
   input wire logic external_count_input,
   input wire logic ext_div8_tick,
   input wire logic rtc_div8_tick,
   output logic count_tick_reg,
   output logic counter_enable_reg,
   output logic watchdog_mode_reg,
   output logic irq_request_reg,
   output logic [NUM_MODULES-1:0] module_flags_reg,
   output logic counter_overflow_flag_reg
);
   // the flags register has room for exactly six module flags
   generate
      if (NUM_MODULES != 6)
      begin : g_bad_count
         $error("counter_array_flags_mode serves exactly six modules");
      end
   endgenerate

   // reset images, so that single fields can be picked out of them
   localparam counter_array_pkg::sfr_byte_t MODE_RESET_VALUE = `CA_MODE_RESET;
   localparam counter_array_pkg::sfr_byte_t FLAGS_RESET_VALUE = `CA_FLAGS_RESET;

   // address decode
   wire logic hit_mode = (sfr_addr == `CA_MODE_ADDR);
   wire logic hit_flags = (sfr_addr == `CA_FLAGS_ADDR);
   wire logic wr_mode = sfr_wr && hit_mode;
   wire logic wr_flags = sfr_wr && hit_flags;

   // mode register state, plus the run bit of the flags register
   logic idle_suspend_select_reg;
   logic watchdog_use_enable_reg;
   logic watchdog_lock_reg;
   counter_array_pkg::timebase_sel_t timebase_select_reg;
   logic overflow_irq_enable_reg;
   logic counter_run_reg;

   // once locked, the watchdog enable holds until the next reset
   wire logic wdog_write_ok = wr_mode && !watchdog_lock_reg;

   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         idle_suspend_select_reg <= MODE_RESET_VALUE[`CA_MODE_IDLE_BIT];
         watchdog_use_enable_reg <= MODE_RESET_VALUE[`CA_MODE_WDOG_BIT];
         watchdog_lock_reg <= MODE_RESET_VALUE[`CA_MODE_LOCK_BIT];
         timebase_select_reg <= MODE_RESET_VALUE[`CA_MODE_SEL_HI:`CA_MODE_SEL_LO];
         overflow_irq_enable_reg <= MODE_RESET_VALUE[`CA_MODE_OVF_IE_BIT];
         counter_run_reg <= FLAGS_RESET_VALUE[`CA_FLAGS_RUN_BIT];
      end
      else
      begin
         if (wr_mode)
         begin
            // [R3] idle setting store
            idle_suspend_select_reg <= sfr_wdata[`CA_MODE_IDLE_BIT];
            // [R8] timebase select store
            timebase_select_reg <= sfr_wdata[`CA_MODE_SEL_HI:`CA_MODE_SEL_LO];
            overflow_irq_enable_reg <= sfr_wdata[`CA_MODE_OVF_IE_BIT];
            // lock can only be set by software
            if (sfr_wdata[`CA_MODE_LOCK_BIT])
               watchdog_lock_reg <= 1'b1;
         end
         if (wdog_write_ok)
            watchdog_use_enable_reg <= sfr_wdata[`CA_MODE_WDOG_BIT];
         if (wr_flags)
            counter_run_reg <= sfr_wdata[`CA_FLAGS_RUN_BIT];
      end
   end

   // sticky flags: index NUM_MODULES is the overflow flag
   wire logic [NUM_MODULES:0] flag_set = {counter_overflow, module_event};
   wire logic [NUM_MODULES:0] flag_wval = {sfr_wdata[`CA_FLAGS_OVF_BIT],
                                           sfr_wdata[`CA_FLAGS_EVT_HI:0]};
   logic [NUM_MODULES:0] flag_q;

   genvar gi;
   generate
      for (gi = 0; gi <= NUM_MODULES; gi++)
      begin : g_flag
         // [R7] event sets flag
         // [R2] software-only clear
         event_flag_cell u_cell
         (
            .clock(clock),
            .srst(srst),
            .set_pulse(flag_set[gi]),
            .write_en(wr_flags),
            .write_val(flag_wval[gi]),
            .flag_reg(flag_q[gi])
         );
      end
   endgenerate

   // [R1] shared interrupt request
   wire logic irq_next = (|(flag_q[NUM_MODULES-1:0] & module_irq_enable))
                         || (flag_q[NUM_MODULES] && overflow_irq_enable_reg);

   // [R4] counting continues in idle when clear
   // [R6] suspend during idle when set
   wire logic enable_next = counter_run_reg && !(cpu_idle && idle_suspend_select_reg);

   // external count pin: two-stage synchroniser, then a third stage for the edge
   logic eci_meta_reg;
   logic eci_sync_reg;
   logic eci_prev_reg;
   wire logic eci_fall = eci_prev_reg && !eci_sync_reg;

   // system clock prescaler shared by the divide-by-12 and divide-by-4 sources
   counter_array_pkg::prescale_t prescale_reg;
   // prescale period for the selected system clock source
   function automatic counter_array_pkg::prescale_t prescale_period
   (
      input counter_array_pkg::timebase_sel_t sel
   );
      if (sel == `CA_TB_SYS_DIV4)
         return `CA_DIV4_COUNT;
      return `CA_DIV12_COUNT;
   endfunction : prescale_period

   wire counter_array_pkg::prescale_t prescale_limit = prescale_period(timebase_select_reg);
   // the period shrinks when software picks the faster source; wrapping on >= avoids
   // a long gap while the prescaler would otherwise run up through all sixteen states
   wire logic prescale_wrap = (prescale_reg >= prescale_limit - 4'h1);
   wire counter_array_pkg::prescale_t prescale_next =
      prescale_wrap ? 4'h0 : prescale_reg + 4'h1;

   // [R8] timebase source mux, reserved code gives no ticks
   wire logic timebase_pulse =
      (timebase_select_reg == `CA_TB_SYS_DIV12) ? prescale_wrap :
      (timebase_select_reg == `CA_TB_SYS_DIV4) ? prescale_wrap :
      (timebase_select_reg == `CA_TB_TIMER0) ? timer0_overflow :
      (timebase_select_reg == `CA_TB_EXT_FALL) ? eci_fall :
      (timebase_select_reg == `CA_TB_SYS) ? 1'b1 :
      (timebase_select_reg == `CA_TB_EXT_DIV8) ? ext_div8_tick :
      (timebase_select_reg == `CA_TB_RTC_DIV8) ? rtc_div8_tick : 1'b0;

   // read mux; unused bit 4 and unmapped addresses read as zero
   wire counter_array_pkg::sfr_byte_t mode_view = {idle_suspend_select_reg,
      watchdog_use_enable_reg, watchdog_lock_reg, 1'b0, timebase_select_reg,
      overflow_irq_enable_reg};
   wire counter_array_pkg::sfr_byte_t flags_view = {flag_q[NUM_MODULES], counter_run_reg,
      flag_q[NUM_MODULES-1:0]};
   wire counter_array_pkg::sfr_byte_t read_next =
      !sfr_rd ? 8'h00 :
      hit_mode ? mode_view :
      hit_flags ? flags_view : 8'h00;

   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         eci_meta_reg <= 1'b1;
         eci_sync_reg <= 1'b1;
         eci_prev_reg <= 1'b1;
         prescale_reg <= 4'h0;
      end
      else
      begin
         eci_meta_reg <= external_count_input;
         eci_sync_reg <= eci_meta_reg;
         eci_prev_reg <= eci_sync_reg;
         // prescaler frozen with the counter so idle suspend holds its phase
         if (enable_next)
            prescale_reg <= prescale_next;
      end
   end

   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         count_tick_reg <= 1'b0;
         counter_enable_reg <= 1'b0;
         watchdog_mode_reg <= 1'b0;
         irq_request_reg <= 1'b0;
         module_flags_reg <= '0;
         counter_overflow_flag_reg <= 1'b0;
         sfr_rdata <= 8'h00;
      end
      else
      begin
         count_tick_reg <= timebase_pulse && enable_next;
         counter_enable_reg <= enable_next;
         // [R5] module 5 as watchdog
         watchdog_mode_reg <= watchdog_use_enable_reg;
         irq_request_reg <= irq_next;
         module_flags_reg <= flag_q[NUM_MODULES-1:0];
         counter_overflow_flag_reg <= flag_q[NUM_MODULES];
         sfr_rdata <= read_next;
      end
   end
endmodule : counter_array_flags_mode

// *** counter_array_flags_mode_asserts.sv ***
// assertions on the counter array flags and mode block
// assumes it is bound to counter_array_flags_mode
`timescale 1ns/1ps
`include "counter_array_consts.svh"
module counter_array_flags_mode_asserts
#(
   parameter int NUM_MODULES = 6
)
(
   input wire logic clock,
   input wire logic srst,
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_rdata,
   input wire logic [NUM_MODULES-1:0] module_event,
   input wire logic [NUM_MODULES-1:0] module_irq_enable,
   input wire logic cpu_idle,
   input wire logic counter_enable_reg,
   input wire logic watchdog_mode_reg,
   input wire logic irq_request_reg,
   input wire logic [NUM_MODULES-1:0] module_flags_reg,
   input wire logic counter_overflow_flag_reg
);
   default clocking @(posedge clock); endclocking
   default disable iff (srst);
   chk_event_sets_flag: assert property (
      |module_event |->
      ##2 (module_flags_reg & $past(module_event, 2)) == $past(module_event, 2))
      else $error("event lost");
   chk_flag_sticky: assert property (
      |($past(module_flags_reg) & ~module_flags_reg) |->
      $past(sfr_wr, 2) && $past(sfr_addr, 2) == `CA_FLAGS_ADDR)
      else $error("flag cleared alone");
   chk_irq_raise: assert property (
      |(module_flags_reg & $past(module_irq_enable)) |-> irq_request_reg)
      else $error("irq missing");
   chk_irq_cause: assert property (
      irq_request_reg && !counter_overflow_flag_reg |->
      |(module_flags_reg & $past(module_irq_enable)))
      else $error("irq without cause");
   chk_read_mode: assert property (
      sfr_rd && sfr_addr == `CA_MODE_ADDR |=>
      sfr_rdata[6] == watchdog_mode_reg && !sfr_rdata[4])
      else $error("mode read bad");
   chk_read_quiet: assert property (
      !(sfr_rd && (sfr_addr == `CA_MODE_ADDR || sfr_addr == `CA_FLAGS_ADDR)) |=>
      sfr_rdata == 8'h00)
      else $error("read data not zero");
   chk_enable_cause: assert property (
      $changed(counter_enable_reg) |-> $past(sfr_wr) || $past(sfr_wr, 2) ||
      $past(cpu_idle) != $past(cpu_idle, 2) || cpu_idle != $past(cpu_idle))
      else $error("enable changed alone");
   chk_wdog_reset: assert property (
      $fell(srst) |=> watchdog_mode_reg)
      else $error("watchdog not on after reset");
   cover property ($rose(irq_request_reg));
   cover property ($fell(counter_enable_reg));
   cover property ($fell(module_flags_reg[0]));
endmodule : counter_array_flags_mode_asserts

bind counter_array_flags_mode counter_array_flags_mode_asserts #(.NUM_MODULES(NUM_MODULES)) u_chk
(
   .clock(clock),
   .srst(srst),
   .sfr_addr(sfr_addr),
   .sfr_wr(sfr_wr),
   .sfr_rd(sfr_rd),
   .sfr_rdata(sfr_rdata),
   .module_event(module_event),
   .module_irq_enable(module_irq_enable),
   .cpu_idle(cpu_idle),
   .counter_enable_reg(counter_enable_reg),
   .watchdog_mode_reg(watchdog_mode_reg),
   .irq_request_reg(irq_request_reg),
   .module_flags_reg(module_flags_reg),
   .counter_overflow_flag_reg(counter_overflow_flag_reg)
);

// *** counter_array_pkg.sv ***
// types shared by the counter array flags and mode block
// assumes nothing beyond the constants header
package counter_array_pkg;
   typedef logic [7:0] sfr_byte_t;
   typedef logic [2:0] timebase_sel_t;
   typedef logic [3:0] prescale_t;
endpackage : counter_array_pkg

// *** event_flag_cell.sv ***
// one sticky event flag with a software write port
// assumes set and write strobes are on the same clock
`timescale 1ns/1ps
module event_flag_cell
(
   input wire logic clock,
   input wire logic srst,
   input wire logic set_pulse,
   input wire logic write_en,
   input wire logic write_val,
   output logic flag_reg
);
   // a hardware set wins over a software clear in the same cycle
   always_ff @(posedge clock)
   begin
      if (srst)
         flag_reg <= 1'b0;
      else if (set_pulse)
         flag_reg <= 1'b1;
      else if (write_en)
         flag_reg <= write_val;
   end
endmodule : event_flag_cell

// *** testbench.sv ***
// self-checking bench for the counter array flags and mode block
// assumes one-cycle register reads and the constants header
`timescale 1ns/1ps
`include "counter_array_consts.svh"
module testbench;
   logic clock = 1'h0, srst = 1'h1, sfr_wr = 1'h0, sfr_rd = 1'h0, cpu_idle = 1'h0;
   logic counter_overflow = 1'h0, timer0_overflow = 1'h0, external_count_input = 1'h1;
   logic ext_div8_tick = 1'h0, rtc_div8_tick = 1'h0;
   logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00;
   logic [5:0] module_event = 6'h00, module_irq_enable = 6'h00, module_flags_reg;
   counter_array_pkg::sfr_byte_t sfr_rdata;
   logic count_tick_reg, counter_enable_reg, watchdog_mode_reg, irq_request_reg;
   logic counter_overflow_flag_reg;
   logic [7:0] exp_ticks [8] = '{8'h02, 8'h06, 8'h08, 8'h04, 8'h18, 8'h0C, 8'h03, 8'h00};
   int n_mismatch = 0, checks_done = 0, cyc = 0, n;
   counter_array_flags_mode u_counter_array_flags_mode
   (
      .clock(clock),
      .srst(srst),
      .sfr_addr(sfr_addr),
      .sfr_wdata(sfr_wdata),
      .sfr_wr(sfr_wr),
      .sfr_rd(sfr_rd),
      .sfr_rdata(sfr_rdata),
      .module_event(module_event),
      .module_irq_enable(module_irq_enable),
      .counter_overflow(counter_overflow),
      .cpu_idle(cpu_idle),
      .timer0_overflow(timer0_overflow),
      .external_count_input(external_count_input),
      .ext_div8_tick(ext_div8_tick),
      .rtc_div8_tick(rtc_div8_tick),
      .count_tick_reg(count_tick_reg),
      .counter_enable_reg(counter_enable_reg),
      .watchdog_mode_reg(watchdog_mode_reg),
      .irq_request_reg(irq_request_reg),
      .module_flags_reg(module_flags_reg),
      .counter_overflow_flag_reg(counter_overflow_flag_reg)
   );
   initial forever #12.5 clock = ~clock;
   // periodic sources at distinct rates, so a wrong mux leg shows up in the tick count
   always @(posedge clock)
   begin
      #2;
      cyc = cyc + 1;
      timer0_overflow = cyc % 3 == 0;
      ext_div8_tick = cyc % 2 == 0;
      rtc_div8_tick = cyc % 8 == 0;
      external_count_input = cyc % 6 < 3;
   end
   task automatic tick(input int k);
      repeat (k) @(posedge clock);
      #2;
   endtask : tick
   task automatic cmp(input logic [7:0] g, input logic [7:0] e);
      checks_done++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("wrong value at %0t: got %h want %h", $time, g, e);
      end
   endtask : cmp
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'h1;
      tick(1);
      sfr_wr = 1'h0;
      tick(1);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      sfr_addr = a;
      sfr_rd = 1'h1;
      tick(1);
      sfr_rd = 1'h0;
      cmp(sfr_rdata, e);
      tick(1);
   endtask : rd
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : give_verdict
   initial
   begin
      repeat (20000) @(posedge clock);
      n_mismatch++;
      $display("wrong value at %0t: timeout", $time);
      give_verdict();
   end
   initial
   begin
      tick(8);
      srst = 1'h0;
      tick(1);
      cmp({7'h00, watchdog_mode_reg}, 8'h01);
      rd(`CA_MODE_ADDR, `CA_MODE_RESET);
      rd(`CA_FLAGS_ADDR, `CA_FLAGS_RESET);
      wr(`CA_MODE_ADDR, 8'h90);
      rd(`CA_MODE_ADDR, 8'h80);
      cmp({7'h00, watchdog_mode_reg}, 8'h00);
      wr(`CA_FLAGS_ADDR, 8'h40);
      cpu_idle = 1'h1;
      tick(3);
      cmp({7'h00, counter_enable_reg}, 8'h00);
      cpu_idle = 1'h0;
      tick(3);
      cmp({7'h00, counter_enable_reg}, 8'h01);
      wr(`CA_MODE_ADDR, 8'h00);
      cpu_idle = 1'h1;
      tick(3);
      cmp({7'h00, counter_enable_reg}, 8'h01);
      cpu_idle = 1'h0;
      $display("test mode and idle done");
      for (int c = 0; c < 8; c++)
      begin
         wr(`CA_MODE_ADDR, 8'(c * 2));
         tick(8);
         n = 0;
         for (int i = 0; i < 24; i++)
         begin
            n += count_tick_reg;
            tick(1);
         end
         cmp(8'(n), exp_ticks[c]);
      end
      $display("test timebase done");
      module_irq_enable = 6'h05;
      module_event = 6'h03;
      tick(1);
      module_event = 6'h00;
      tick(2);
      cmp({2'h0, module_flags_reg}, 8'h03);
      cmp({7'h00, irq_request_reg}, 8'h01);
      tick(20);
      rd(`CA_FLAGS_ADDR, 8'h43);
      wr(`CA_FLAGS_ADDR, 8'h42);
      tick(2);
      cmp({2'h0, module_flags_reg}, 8'h02);
      cmp({7'h00, irq_request_reg}, 8'h00);
      counter_overflow = 1'h1;
      tick(1);
      counter_overflow = 1'h0;
      tick(2);
      cmp({7'h00, counter_overflow_flag_reg}, 8'h01);
      rd(`CA_FLAGS_ADDR, 8'hC2);
      wr(`CA_MODE_ADDR, 8'h01);
      cmp({7'h00, irq_request_reg}, 8'h01);
      wr(`CA_FLAGS_ADDR, 8'h40);
      rd(`CA_FLAGS_ADDR, 8'h40);
      wr(`CA_MODE_ADDR, 8'h20);
      wr(`CA_MODE_ADDR, 8'h60);
      rd(`CA_MODE_ADDR, 8'h20);
      // a second reset must release the lock and turn the watchdog back on
      srst = 1'h1;
      tick(2);
      srst = 1'h0;
      tick(1);
      cmp({7'h00, watchdog_mode_reg}, 8'h01);
      wr(`CA_MODE_ADDR, 8'h00);
      rd(`CA_MODE_ADDR, 8'h00);
      rd(8'h10, 8'h00);
      $display("test flags and lock done");
      give_verdict();
   end
endmodule : testbench
